// file: common/adc_seq_pkg.sv
// Purpose: Shared constants and carriers of the conversion sequencer
// Assumes: 50 MHz system clock, 1.024 MHz oscillator timebase
// Notes:   Periods are stored per data-rate code, code 0 is the slowest rate

package adc_seq_pkg;

	// ----------------------------------------
	// Clock and timing figures
	// ----------------------------------------
	localparam int CLK_PERIOD_NS     = 20;          // System clock period
	localparam int CLK_HZ            = 50_000_000;  // System clock rate
	localparam int OSC_HZ            = 1_024_000;   // Oscillator rate
	localparam int MOD_DIV           = 4;           // Modulator divider
	localparam int POR_RELEASE_US    = 500;         // Power-on hold time
	localparam int POR_CYCLES        = POR_RELEASE_US * 1000 / CLK_PERIOD_NS;
	localparam int REF_SETTLE_US     = 25;          // Reference settling allowance
	localparam int REF_SETTLE_CYCLES =
		(REF_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LEAD_HALF_PERIODS = 57;          // 28.5 periods, counted on both edges
	localparam int DRH_PERIODS       = 2;           // Ready release before unread result

	// ----------------------------------------
	// Conversion periods per rate code 20/90/330/1000
	// ----------------------------------------
	localparam logic [3:0][15:0] CONT_PERIODS   = {16'h040c, 16'h0c2c, 16'h2d0c, 16'hc7f8};
	localparam logic [3:0][15:0] SINGLE_PERIODS = {16'h0425, 16'h0c45, 16'h2d25, 16'hc80d};

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_RESET      = 8'h06;  // Low bit ignored
	localparam logic [7:0] CMD_RESET_MASK = 8'hfe;
	localparam logic [7:0] CMD_START      = 8'h08;
	localparam logic [7:0] CMD_SLEEP      = 8'h02;

	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam logic [3:0] REG_CFG    = 4'h0;       // Configuration, read/write
	localparam logic [3:0] REG_STATUS = 4'h1;       // Status, read only
	localparam logic [6:0] CFG_RST    = 7'h00;      // Internal reference, single-shot
	localparam logic [2:0] MUX_SHORT  = 3'h6;       // Both inputs to mid-supply
	localparam logic [3:0] PINS_INIT  = 4'h7;       // Pins idle high, supply low

	// Operating states, Gray along the usual path
	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_IDLE = 2'h1,
		ST_LEAD = 2'h3,
		ST_CONV = 2'h2
	} seq_state_e;

	// Configuration word
	typedef struct packed {
		logic [2:0] mux;      // Input selection
		logic [1:0] rate;     // Data-rate code
		logic       cont;     // Conversion mode bit
		logic       ref_ext;  // External reference select
	} cfg_s;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;

	// Pins from outside the clock domain
	typedef struct packed {
		logic supply_ok;
		logic reset_n;
		logic scl;
		logic sda;
	} pins_s;

endpackage : adc_seq_pkg

// file: hw/adc_conversion_sequencer.sv
// Purpose: Conversion sequencing, reset and reference control of the converter
// Assumes: Serial framing outside gives cmd_window_i per command byte
// Notes:   All conversion timing counts oscillator edges

module adc_conversion_sequencer #(
	parameter logic [3:0][15:0] CONT_PERIODS   = adc_seq_pkg::CONT_PERIODS,
	parameter logic [3:0][15:0] SINGLE_PERIODS = adc_seq_pkg::SINGLE_PERIODS,
	parameter int               POR_CYCLES     = adc_seq_pkg::POR_CYCLES
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	// Pins from outside the clock domain
	input  wire adc_seq_pkg::pins_s   pins_i,
	// Command byte framing, same clock
	input  wire logic                 cmd_window_i,
	// Register port
	input  wire adc_seq_pkg::reg_req_s reg_req_i,
	output logic [7:0]                rdata_o,
	// Result hand-off
	input  wire logic                 result_taken_i,
	output logic                      result_ready_n_o,
	output logic                      result_ready_n_oe_o,
	// Analog and filter control
	output logic                      ref_ext_sel_o,
	output logic                      ref_settled_o,
	output logic                      analog_on_o,
	output logic                      offset_short_o,
	output logic [1:0]                decim_rate_o,
	output logic                      mod_tick_o,
	output logic                      conv_done_o,
	output logic                      comm_ready_o
);

	default clocking dflt @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// ----------------------------------------
	// Types and constants
	// ----------------------------------------
	localparam logic [10:0] REF_CYC  = 11'(adc_seq_pkg::REF_SETTLE_CYCLES);
	localparam logic [16:0] LEAD_CNT = 17'(adc_seq_pkg::LEAD_HALF_PERIODS);
	localparam logic [16:0] DRH_CNT  = 17'(2 * adc_seq_pkg::DRH_PERIODS + 1);
	localparam logic [23:0] POR_LAST = 24'(POR_CYCLES - 1);

	// Whole state of the sequencer
	typedef struct packed {
		adc_seq_pkg::seq_state_e st;      // Operating state
		logic [16:0]             cnt;     // Oscillator edges left
		adc_seq_pkg::cfg_s       cfg;     // Configuration
		logic                    run_cont; // Mode taken at start
		logic                    sleep_pend; // Sleep after conversion
		logic                    rdy_low; // Ready pin pulled low
		logic                    done_p;  // Result complete pulse
		logic [7:0]              shreg;   // Serial command shifter
		logic [2:0]              nfall;   // Falling edges in byte
		logic                    scl_q;   // Previous serial clock
		logic [23:0]             por_cnt; // Power-on hold count
		logic [10:0]             ref_cnt; // Reference settle count
		logic                    ref_ok;  // Reference settled
		logic [7:0]              rdata;   // Read data
		logic [2:0]              mod_seen; // Edges since modulator tick
	} seq_s;

	seq_s                s_q;
	seq_s                s_d;
	adc_seq_pkg::pins_s  pins;       // Filtered pin levels
	logic                osc_edge;   // Oscillator edge pulse
	logic                osc_mod;    // Modulator tick pulse
	logic                cmd_hit;    // Eighth falling edge seen
	logic                cmd_ok;     // Command accepted
	logic                is_start;
	logic                is_sleep;
	logic                is_reset;
	logic                rst_soft;   // Pin or command reset

	// Refuse values the counters cannot hold
	for (genvar r = 0; r < 4; r++) begin : g_chk
		if (CONT_PERIODS[r] <= 16'(2 * adc_seq_pkg::DRH_PERIODS) || SINGLE_PERIODS[r] == '0)
		begin : g_bad
			$error("adc_conversion_sequencer: period too short");
		end
	end
	if (POR_CYCLES < 1 || POR_CYCLES > 2 ** 24) begin : g_bad_por
		$error("adc_conversion_sequencer: POR_CYCLES out of range");
	end

	// Edge count of one conversion
	function automatic logic [16:0] period_for(input logic cont, input logic [1:0] rate);
		logic [15:0] p;
		p = cont ? CONT_PERIODS[rate] : SINGLE_PERIODS[rate];
		return {p, 1'b0};
	endfunction : period_for

	// ----------------------------------------
	// Pin synchroniser and timebase
	// ----------------------------------------
	pin_sync #(
		.W    (4),
		.INIT (adc_seq_pkg::PINS_INIT)
	) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pin_i   (pins_i),
		.level_o (pins)
	);

	osc_tick_gen u_osc (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.edge_o     (osc_edge),
		.mod_tick_o (osc_mod)
	);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign cmd_hit  = cmd_window_i && !pins.scl && s_q.scl_q && s_q.nfall == 3'h7;
	assign cmd_ok   = cmd_hit && s_q.st != adc_seq_pkg::ST_HOLD;
	assign is_start = cmd_ok && s_q.shreg == adc_seq_pkg::CMD_START;
	assign is_sleep = cmd_ok && s_q.shreg == adc_seq_pkg::CMD_SLEEP;
	assign is_reset = cmd_ok &&
		(s_q.shreg & adc_seq_pkg::CMD_RESET_MASK) == adc_seq_pkg::CMD_RESET;
	assign rst_soft = s_q.st != adc_seq_pkg::ST_HOLD && (!pins.reset_n || is_reset);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d        = s_q;
		s_d.done_p = 1'b0;
		s_d.rdata  = 8'h00;
		s_d.scl_q  = pins.scl;

		// Serial byte capture
		if (!cmd_window_i) begin
			s_d.nfall = 3'h0;
		end else if (pins.scl && !s_q.scl_q) begin
			s_d.shreg = {s_q.shreg[6:0], pins.sda};
		end else if (!pins.scl && s_q.scl_q) begin
			s_d.nfall = s_q.nfall + 3'h1; // Wraps after the eighth
		end

		// Modulator alignment helper
		if (osc_mod) begin
			s_d.mod_seen = 3'h0;
		end else if (osc_edge) begin
			s_d.mod_seen = s_q.mod_seen + 3'h1;
		end

		// Register reads
		if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				adc_seq_pkg::REG_CFG: begin
					s_d.rdata = {1'b0, s_q.cfg};
				end
				adc_seq_pkg::REG_STATUS: begin
					s_d.rdata = {3'h0, s_q.ref_ok, s_q.rdy_low, s_q.sleep_pend, s_q.st};
				end
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Register writes, refused while held in reset
		if (reg_req_i.wr && reg_req_i.addr == adc_seq_pkg::REG_CFG &&
			s_q.st != adc_seq_pkg::ST_HOLD) begin
			if (s_q.cfg.ref_ext && !reg_req_i.wdata[0]) begin
				s_d.ref_cnt = REF_CYC;
			end
			s_d.cfg = reg_req_i.wdata[6:0];
		end

		// Result taken releases the ready pin
		if (result_taken_i) begin
			s_d.rdy_low = 1'b0;
		end

		// Reference settle countdown
		if (s_q.ref_cnt != 11'h000) begin
			s_d.ref_cnt = s_q.ref_cnt - 11'h001;
		end

		// Sequencer
		unique case (s_q.st)
			adc_seq_pkg::ST_HOLD: begin
				// Power-on hold
				if (s_q.por_cnt == POR_LAST) begin
					s_d.st      = adc_seq_pkg::ST_IDLE;
					s_d.ref_cnt = REF_CYC;
				end else begin
					s_d.por_cnt = s_q.por_cnt + 24'h00_0001;
				end
			end
			adc_seq_pkg::ST_IDLE: begin
				// Low power, waits for start
				s_d.cnt = 17'h0_0000;
			end
			adc_seq_pkg::ST_LEAD: begin
				// Continuous start-up delay
				if (osc_edge) begin
					if (s_q.cnt == 17'h0_0001) begin
						s_d.st  = adc_seq_pkg::ST_CONV;
						s_d.cnt = period_for(1'b1, s_q.cfg.rate);
					end else begin
						s_d.cnt = s_q.cnt - 17'h0_0001;
					end
				end
			end
			adc_seq_pkg::ST_CONV: begin
				// Conversion in progress
				if (osc_edge) begin
					if (s_q.cnt == 17'h0_0001) begin
						s_d.rdy_low = 1'b1;
						s_d.done_p  = 1'b1;
						if (!s_q.run_cont || s_q.sleep_pend) begin
							s_d.st         = adc_seq_pkg::ST_IDLE;
							s_d.sleep_pend = 1'b0;
						end else begin
							s_d.cnt = period_for(1'b1, s_q.cfg.rate);
						end
					end else begin
						s_d.cnt = s_q.cnt - 17'h0_0001;
						if (s_q.run_cont && s_q.cnt == DRH_CNT) begin
							s_d.rdy_low = 1'b0; // Unread result released
						end
					end
				end
			end
		endcase

		// Commands
		if (is_start) begin
			if (s_q.st == adc_seq_pkg::ST_IDLE) begin
				s_d.ref_cnt = REF_CYC;
			end
			s_d.run_cont   = s_q.cfg.cont;
			s_d.sleep_pend = 1'b0;
			if (s_q.cfg.cont) begin
				s_d.st  = adc_seq_pkg::ST_LEAD;
				s_d.cnt = LEAD_CNT;
			end else begin
				s_d.st  = adc_seq_pkg::ST_CONV;
				s_d.cnt = period_for(1'b0, s_q.cfg.rate);
			end
		end else if (is_sleep) begin
			if (s_q.st == adc_seq_pkg::ST_CONV) begin
				s_d.sleep_pend = 1'b1;
			end else if (s_q.st == adc_seq_pkg::ST_LEAD) begin
				s_d.st = adc_seq_pkg::ST_IDLE;
			end
		end

		// Resets act at once
		if (!pins.supply_ok || rst_soft) begin
			s_d.st         = pins.supply_ok ? adc_seq_pkg::ST_IDLE : adc_seq_pkg::ST_HOLD;
			s_d.cnt        = 17'h0_0000;
			s_d.cfg        = adc_seq_pkg::CFG_RST;
			s_d.run_cont   = 1'b0;
			s_d.sleep_pend = 1'b0;
			s_d.rdy_low    = 1'b0;
			s_d.done_p     = 1'b0;
			if (!pins.supply_ok) begin
				s_d.por_cnt = 24'h00_0000;
			end
		end

		s_d.ref_ok = s_d.ref_cnt == 11'h000;
	end

	// Registers
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_o             = s_q.rdata;
	assign result_ready_n_o    = 1'b0;        // Open drain, low only
	assign result_ready_n_oe_o = s_q.rdy_low;
	assign ref_ext_sel_o       = s_q.cfg.ref_ext;
	assign ref_settled_o       = s_q.ref_ok;
	assign analog_on_o         = s_q.st == adc_seq_pkg::ST_LEAD || s_q.st == adc_seq_pkg::ST_CONV;
	assign offset_short_o      = s_q.cfg.mux == adc_seq_pkg::MUX_SHORT;
	assign decim_rate_o        = s_q.cfg.rate;
	assign mod_tick_o          = osc_mod && analog_on_o;
	assign conv_done_o         = s_q.done_p;
	assign comm_ready_o        = s_q.st != adc_seq_pkg::ST_HOLD;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_MOD_QUARTER: assert property (
		osc_mod |-> osc_edge && s_q.mod_seen == 3'h7)
		else $error("modulator tick not every eighth oscillator edge");
	AST_LEAD_LOAD: assert property (
		(is_start && s_q.cfg.cont && !rst_soft && pins.supply_ok)
		|=> s_q.st == adc_seq_pkg::ST_LEAD && s_q.cnt == LEAD_CNT)
		else $error("continuous start delay not loaded");
	AST_CONT_PERIOD: assert property (
		(s_q.st == adc_seq_pkg::ST_LEAD && osc_edge && s_q.cnt == 17'h0_0001 &&
		 !cmd_ok && !rst_soft && pins.supply_ok)
		|=> s_q.st == adc_seq_pkg::ST_CONV &&
			s_q.cnt == period_for(1'b1, $past(s_q.cfg.rate)))
		else $error("continuous period not loaded after start delay");
	AST_SINGLE_LOAD: assert property (
		(is_start && !s_q.cfg.cont && !rst_soft && pins.supply_ok)
		|=> s_q.st == adc_seq_pkg::ST_CONV &&
			s_q.cnt == period_for(1'b0, $past(s_q.cfg.rate)))
		else $error("single-shot period not loaded");
	AST_READY_LOW: assert property (
		s_q.done_p |-> result_ready_n_oe_o && !result_ready_n_o)
		else $error("ready pin not low with new result");
	AST_CONT_NEXT: assert property (
		(s_q.st == adc_seq_pkg::ST_CONV && osc_edge && s_q.cnt == 17'h0_0001 &&
		 s_q.run_cont && !s_q.sleep_pend && !cmd_ok && !rst_soft && pins.supply_ok)
		|=> s_q.st == adc_seq_pkg::ST_CONV && s_q.done_p ##1 !s_q.done_p)
		else $error("continuous conversion did not restart");
	AST_SINGLE_STOP: assert property (
		(s_q.st == adc_seq_pkg::ST_CONV && osc_edge && s_q.cnt == 17'h0_0001 &&
		 !s_q.run_cont && !cmd_ok && !rst_soft && pins.supply_ok)
		|=> s_q.st == adc_seq_pkg::ST_IDLE && !analog_on_o)
		else $error("single-shot did not return to low power");
	AST_SLEEP_WAIT: assert property (
		(is_sleep && s_q.st == adc_seq_pkg::ST_CONV && s_q.cnt > 17'h0_0002 && !osc_edge &&
		 !rst_soft && pins.supply_ok)
		|=> s_q.st == adc_seq_pkg::ST_CONV && s_q.sleep_pend)
		else $error("sleep aborted a running conversion");
	AST_RESET_DEFAULT: assert property (
		rst_soft |=> s_q.cfg == adc_seq_pkg::CFG_RST && !analog_on_o && !ref_ext_sel_o)
		else $error("reset did not restore defaults");
	AST_HOLD_REFUSE: assert property (
		(s_q.st == adc_seq_pkg::ST_HOLD && reg_req_i.wr) |=> $stable(s_q.cfg))
		else $error("configuration written during power-on hold");
	COV_CONT_DONE: cover property (s_q.run_cont && s_q.done_p);
	COV_SINGLE_DONE: cover property (!s_q.run_cont && s_q.done_p);
	COV_SLEEP_END: cover property (s_q.sleep_pend ##1 !s_q.sleep_pend && s_q.done_p);

endmodule : adc_conversion_sequencer

// file: hw/osc_tick_gen.sv
// Purpose: Oscillator edge and modulator tick generator
// Assumes: CLK_HZ well above twice OSC_HZ
// Notes:   Fractional accumulator, one pulse per oscillator edge

module osc_tick_gen #(
	parameter int CLK_HZ  = adc_seq_pkg::CLK_HZ,
	parameter int OSC_HZ  = adc_seq_pkg::OSC_HZ,
	parameter int MOD_DIV = adc_seq_pkg::MOD_DIV
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// Tick pulses
	output logic      edge_o,      // Each oscillator edge
	output logic      mod_tick_o   // Each modulator clock
);

	localparam int HW = $clog2(2 * MOD_DIV);

	// Generator state
	typedef struct packed {
		logic [31:0]   acc;   // Phase accumulator
		logic [HW-1:0] hcnt;  // Edges within a modulator period
		logic          edge_p;
		logic          mod_p;
	} osc_s;

	osc_s        s_q;
	osc_s        s_d;
	logic [31:0] sum;

	// Refuse rates the accumulator cannot serve
	if (2 * OSC_HZ >= CLK_HZ || MOD_DIV < 1) begin : g_bad_rate
		$error("osc_tick_gen: unsupported rates");
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d        = s_q;
		s_d.edge_p = 1'b0;
		s_d.mod_p  = 1'b0;
		sum        = s_q.acc + 32'(2 * OSC_HZ);
		if (sum >= 32'(CLK_HZ)) begin
			// One oscillator edge
			s_d.acc    = sum - 32'(CLK_HZ);
			s_d.edge_p = 1'b1;
			if (s_q.hcnt == HW'(2 * MOD_DIV - 1)) begin
				s_d.hcnt  = '0;
				s_d.mod_p = 1'b1;
			end else begin
				s_d.hcnt = s_q.hcnt + HW'(1);
			end
		end else begin
			s_d.acc = sum;
		end
	end

	// Registers
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign edge_o     = s_q.edge_p;
	assign mod_tick_o = s_q.mod_p;

endmodule : osc_tick_gen

// file: hw/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk_i
// Notes:   Level follows once stages two and three agree

module pin_sync #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	// Raw and filtered levels
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);

	// Stage registers
	typedef struct packed {
		logic [W-1:0] s1;   // First stage, read by s2 only
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;  // Filtered level
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d     = s_q;
		s_d.s1  = pin_i;
		s_d.s2  = s_q.s1;
		s_d.s3  = s_q.s2;
		s_d.lvl = (s_q.s2 & s_q.s3) | (s_q.lvl & (s_q.s2 ^ s_q.s3));
	end

	// Registers
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q <= {INIT, INIT, INIT, INIT};
		end else begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.lvl;

endmodule : pin_sync

// file: verification/adc_conversion_sequencer_test.sv
// Purpose: Self-checking bench of the conversion sequencer
// Assumes: Shortened periods and power-on hold
// Notes:   Times in ns, one oscillator period is 976.5625 ns
module adc_conversion_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals and case table
	// ----------------------------------------
	localparam logic [3:0][15:0] CP = {16'h0018, 16'h0014, 16'h0012, 16'h0010};
	localparam logic [3:0][15:0] SP = {16'h001a, 16'h0016, 16'h0014, 16'h0012};
	localparam real T_OSC = 976.5625;
	typedef struct {logic [7:0] cfg; int per;} row_s;
	row_s rows [8] = '{'{8'h60, 18}, '{8'h05, 20}, '{8'h08, 22}, '{8'h0d, 26},
		'{8'h02, 16}, '{8'h07, 18}, '{8'h0a, 20}, '{8'h0f, 24}};
	logic clk_i = 0, reset_i = 1, supply_ok = 0, reset_n = 1, taken = 0;
	logic scl, sda, window, oe, ref_ext, settled, analog_on, short_o, comm, rdy_n, mod_t, done;
	logic [1:0] rate;
	logic [7:0] rdata, d;
	adc_seq_pkg::reg_req_s req = '0;
	int n_mismatch = 0, compares = 0, cycles = 0;
	int n_done = 0, n_mod = 0, m0;  // Completions and modulator ticks seen
	realtime t0, t1;
	// Clock and hang guard
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (done === 1'b1) n_done <= n_done + 1;
		if (mod_t === 1'b1) n_mod <= n_mod + 1;
		if (cycles == 60000) begin
			n_mismatch++;
			final_report();
		end
	end
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	host_link host_u (.clk_i(clk_i), .scl_o(scl), .sda_o(sda), .window_o(window));
	adc_conversion_sequencer #(.CONT_PERIODS(CP), .SINGLE_PERIODS(SP), .POR_CYCLES(20)) dut_u (
		.clk_i(clk_i), .reset_i(reset_i), .pins_i({supply_ok, reset_n, scl, sda}),
		.cmd_window_i(window), .reg_req_i(req), .rdata_o(rdata), .result_taken_i(taken),
		.result_ready_n_o(rdy_n), .result_ready_n_oe_o(oe), .ref_ext_sel_o(ref_ext),
		.ref_settled_o(settled), .analog_on_o(analog_on), .offset_short_o(short_o),
		.decim_rate_o(rate), .mod_tick_o(mod_t), .conv_done_o(done), .comm_ready_o(comm));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i) req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_i) req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_i) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i) req.rd <= 1'b0;
		#1 v = rdata;
	endtask : rd
	// Wait until the ready pin is pulled low afresh
	task automatic wait_rdy(output realtime t);
		for (int i = 0; i < 4000 && oe !== 1'b0; i++) @(posedge clk_i);
		for (int i = 0; i < 4000 && oe !== 1'b1; i++) @(posedge clk_i);
		t = $realtime;
		chk(oe, 1'b1);
		chk(rdy_n, 1'b0);
	endtask : wait_rdy
	task automatic near(input realtime got, input real exp, input real tol);
		chk(got > exp - tol && got < exp + tol, 1'b1);
	endtask : near
	// Wait for the analog part to power down, then release ready
	task automatic wait_off;
		for (int i = 0; i < 2000 && analog_on !== 1'b0; i++) @(posedge clk_i);
		chk(analog_on, 1'b0);
		@(posedge clk_i) taken <= 1'b1;
		@(posedge clk_i) taken <= 1'b0;
		#1 chk(oe, 1'b0);
	endtask : wait_off
	task automatic final_report;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		host_u.send(adc_seq_pkg::CMD_START);
		chk(analog_on, 1'b0);
		supply_ok <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk(comm, 1'b0);
		wr(adc_seq_pkg::REG_CFG, 8'h0f);
		repeat (20) @(posedge clk_i);
		chk(comm, 1'b1);
		chk(settled, 1'b0);
		rd(adc_seq_pkg::REG_CFG, d);
		chk(d, 8'h00);
		rd(4'h9, d);
		chk(d, 8'h00);
		repeat (1260) @(posedge clk_i);
		chk(settled, 1'b1);
		chk(analog_on, 1'b0);
		rd(adc_seq_pkg::REG_STATUS, d);
		chk(d, 8'h11);
		// Case table: every rate in both modes
		foreach (rows[k]) begin
			wr(adc_seq_pkg::REG_CFG, rows[k].cfg);
			#1 chk(ref_ext, rows[k].cfg[0]);
			chk(rate, rows[k].cfg[3:2]);
			chk(short_o, rows[k].cfg[6:4] == 3'h6);
			m0 = n_mod;
			host_u.send(adc_seq_pkg::CMD_START);
			wait_rdy(t0);
			if (rows[k].cfg[1]) begin
				// Centre shifted for sync delay and free-running edge phase
				near(t0 - host_u.t_latch, (28.5 + rows[k].per) * T_OSC - 120, 300);
				wait_rdy(t1);
				near(t1 - t0, rows[k].per * T_OSC, 100);
				host_u.send(adc_seq_pkg::CMD_SLEEP);
				wait_rdy(t0);
				near(t0 - t1, rows[k].per * T_OSC, 100);
			end else begin
				near(t0 - host_u.t_latch, rows[k].per * T_OSC - 120, 300);
			end
			wait_off();
			near(n_mod - m0, (rows[k].cfg[1] ? 28.5 + 3 * rows[k].per : rows[k].per) / 4.0, 1);
		end
		// Reset command abandons a running conversion
		wr(adc_seq_pkg::REG_CFG, 8'h0c);
		host_u.send(adc_seq_pkg::CMD_START);
		host_u.send(adc_seq_pkg::CMD_RESET | 8'h01);
		repeat (5) @(posedge clk_i);
		chk(analog_on, 1'b0);
		repeat (1500) @(posedge clk_i);
		chk(oe, 1'b0);
		rd(adc_seq_pkg::REG_CFG, d);
		chk(d, 8'h00);
		// Reset pin during continuous mode
		wr(adc_seq_pkg::REG_CFG, 8'h0e);
		host_u.send(adc_seq_pkg::CMD_START);
		@(posedge clk_i) reset_n <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk(analog_on, 1'b0);
		rd(adc_seq_pkg::REG_CFG, d);
		chk(d, 8'h00);
		reset_n <= 1'b1;
		// Supply loss puts the block back into power-on hold
		supply_ok <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk(comm, 1'b0);
		chk(n_done, 16);
		final_report();
	end
endmodule : adc_conversion_sequencer_test

// file: verification/host_link.sv
// Purpose: Host side of the serial command link
// Assumes: Serial lines pulled up while released
// Notes:   Serial clock stands high between commands, low just before a frame opens, 160 ns bit period
module host_link (
	// Clock of the framing signal
	input  wire logic clk_i,
	// Serial lines and framing
	output logic      scl_o,
	output logic      sda_o,
	output logic      window_o
);
	timeunit 1ns;
	timeprecision 1ps;
	realtime t_latch;  // Time of the last eighth falling edge
	// Idle levels of a released bus
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		window_o = 1'b0;
	end
	// Send one command byte, MSB first
	task automatic send(input logic [7:0] cmd);
		@(posedge clk_i) scl_o <= 1'b0;  // Clock low before the frame opens
		repeat (6) @(posedge clk_i);
		window_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		#5;  // Serial edges stay off the sampling edge
		for (int i = 7; i >= 0; i--) begin
			#40 sda_o = cmd[i];
			#40 scl_o = 1'b1;
			#80 scl_o = 1'b0;
		end
		t_latch = $realtime;
		#40 sda_o = 1'b1;
		#40 scl_o = 1'b1;
		repeat (10) @(posedge clk_i);
		window_o <= 1'b0;
	endtask : send
endmodule : host_link
